//--- rtl/pot_ctrl.sv
// pulse output trigger and mode control with avalon-mm register access
// Notes on behaviour
// - trigger select register is 8 bits, read/write, resets to all ones.
// - standby never changes trigger or mode registers; only reset or write.
// - bits 7:6 pick timer channel 0 to 3 triggering group 3.
// - bits 5:4 pick timer channel 0 to 3 triggering group 2.
// - bits 3:2 pick timer channel 0 to 3 triggering group 1.
// - bits 1:0 pick timer channel 0 to 3 triggering group 0.
// - output mode register is 8 bits, resets to F0, all groups ordinary.
// - mode bits 7:4 always read one; software writes ones there.
// - gap bit clear: group updates only on compare-match A of its channel.
// - gap bit set: match B clears falling bits, match A copies all enabled bits.
// - on the event, enabled bits copy staged data to port; others hold.
// - gap mode: B clears 1-to-0 bits, later A sets 0-to-1 bits.
module pot_ctrl #(
  parameter int unsigned CHANNELS = pot_pkg::CHANNELS,
  parameter int unsigned PORT_W   = pot_pkg::PORT_W
) (
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  input  wire logic [pot_pkg::ADDR_W-1:0]   i_avs_address,
  input  wire logic                         i_avs_read,
  input  wire logic                         i_avs_write,
  input  wire logic [pot_pkg::DATA_W-1:0]   i_avs_writedata,
  input  wire logic [pot_pkg::BE_W-1:0]     i_avs_byteenable,
  output logic      [pot_pkg::DATA_W-1:0]   o_avs_readdata,
  output logic                              o_avs_waitrequest,
  input  wire logic [CHANNELS-1:0]          i_cmp_a,
  input  wire logic [CHANNELS-1:0]          i_cmp_b,
  output logic      [PORT_W-1:0]            o_port_data
);
  localparam int unsigned GW = pot_pkg::GROUP_W;
  localparam int unsigned NG = pot_pkg::GROUPS;

  pot_pkg::pot_bus_state_t state;
  logic [7:0]            output_trigger_select;
  logic [3:0]            gap_mode;
  logic [PORT_W-1:0]     staged_output_data;
  logic [PORT_W-1:0]     staged_data_enable;
  logic [CHANNELS-1:0]   cmp_a_q;
  logic [CHANNELS-1:0]   cmp_b_q;
  logic [PORT_W-1:0]     port_base;
  logic [PORT_W-1:0]     next_port;
  logic [NG-1:0]         hit_a;
  logic [NG-1:0]         hit_b;
  logic [pot_pkg::DATA_W-1:0] next_readdata;
  logic                  req;
  logic                  fire_wr;
  logic                  lane0;
  logic                  wr_trig;
  logic                  wr_mode;
  logic                  wr_ndata;
  logic                  wr_nen;
  logic                  wr_port;

  assign req      = i_avs_read | i_avs_write;
  // a write lands only at the edge where waitrequest is seen low
  assign fire_wr  = i_avs_write && (state == pot_pkg::POT_BUS_ACK);
  assign lane0    = i_avs_byteenable[0];
  assign wr_trig  = fire_wr && lane0 && (i_avs_address == pot_pkg::OFF_TRIG);
  assign wr_mode  = fire_wr && lane0 && (i_avs_address == pot_pkg::OFF_MODE);
  assign wr_ndata = fire_wr && (i_avs_address == pot_pkg::OFF_NDATA);
  assign wr_nen   = fire_wr && (i_avs_address == pot_pkg::OFF_NEN);
  assign wr_port  = fire_wr && (i_avs_address == pot_pkg::OFF_PORT);

  // bus handshake: one wait cycle, then a single-cycle acknowledge
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state             <= pot_pkg::POT_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
    end else begin
      unique case (state)
        pot_pkg::POT_BUS_IDLE: begin
          if (req) begin
            state             <= pot_pkg::POT_BUS_ACK;
            o_avs_waitrequest <= 1'b0;
          end
        end
        pot_pkg::POT_BUS_ACK: begin
          state             <= pot_pkg::POT_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    next_readdata = '0;
    unique case (i_avs_address)
      pot_pkg::OFF_TRIG:  next_readdata[7:0] = output_trigger_select;
      pot_pkg::OFF_MODE:  next_readdata[7:0] = {pot_pkg::MODE_ONES,
                                                gap_mode};
      pot_pkg::OFF_NDATA: next_readdata[PORT_W-1:0] = staged_output_data;
      pot_pkg::OFF_NEN:   next_readdata[PORT_W-1:0] = staged_data_enable;
      pot_pkg::OFF_PORT:  next_readdata[PORT_W-1:0] = o_port_data;
      default:            next_readdata = '0;
    endcase
  end

  // read data is captured as the wait cycle ends and holds through the ack
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_avs_readdata <= '0;
    end else if (state == pot_pkg::POT_BUS_IDLE && i_avs_read) begin
      o_avs_readdata <= next_readdata;
    end
  end

  // no standby input exists here: contents move only on reset or write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      output_trigger_select <= pot_pkg::TRIG_RST;
    end else if (wr_trig) begin
      output_trigger_select <= i_avs_writedata[7:0];
    end
  end

  // upper mode bits are not stored; they are forced to one on read
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gap_mode <= pot_pkg::MODE_RST[3:0];
    end else if (wr_mode) begin
      gap_mode <= i_avs_writedata[3:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      staged_output_data <= pot_pkg::NDATA_RST;
    end else if (wr_ndata) begin
      staged_output_data <= pot_pkg::lane_merge(staged_output_data,
                                                i_avs_writedata,
                                                i_avs_byteenable);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      staged_data_enable <= pot_pkg::NEN_RST;
    end else if (wr_nen) begin
      staged_data_enable <= pot_pkg::lane_merge(staged_data_enable,
                                                i_avs_writedata,
                                                i_avs_byteenable);
    end
  end

  // strobes are registered once so all groups see the same sample
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cmp_a_q <= '0;
      cmp_b_q <= '0;
    end else begin
      cmp_a_q <= i_cmp_a;
      cmp_b_q <= i_cmp_b;
    end
  end

  // a software port write is applied first; a same-cycle transfer wins
  always_comb begin
    port_base = o_port_data;
    if (wr_port) begin
      port_base = pot_pkg::lane_merge(o_port_data, i_avs_writedata,
                                      i_avs_byteenable);
    end
  end

  for (genvar g = 0; g < NG; g++) begin : grp
    pot_group #(
      .CHANNELS (CHANNELS),
      .GROUP_W  (GW)
    ) u_group (
      .i_sel      (pot_pkg::trig_field(output_trigger_select, g)),
      .i_gap_mode (gap_mode[g]),
      .i_cmp_a    (cmp_a_q),
      .i_cmp_b    (cmp_b_q),
      .i_staged   (staged_output_data[g*GW +: GW]),
      .i_enable   (staged_data_enable[g*GW +: GW]),
      .i_current  (port_base[g*GW +: GW]),
      .o_next     (next_port[g*GW +: GW]),
      .o_hit_a    (hit_a[g]),
      .o_hit_b    (hit_b[g])
    );
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_port_data <= pot_pkg::PORT_RST;
    end else begin
      o_port_data <= next_port;
    end
  end

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property reset_value_p(logic [7:0] v, logic [7:0] exp);
    @(posedge i_clock) disable iff (1'b0)
      i_rst |=> (v == exp);
  endproperty

  trig_reset_a: assert property (
    reset_value_p(output_trigger_select, pot_pkg::TRIG_RST))
    else $error("trigger select not all ones after reset");

  mode_reset_a: assert property (
    reset_value_p({pot_pkg::MODE_ONES, gap_mode}, pot_pkg::MODE_RST))
    else $error("mode register not F0 after reset");

  regs_hold_a: assert property (
    !wr_trig && !wr_mode |=> $stable(output_trigger_select)
                             && $stable(gap_mode))
    else $error("control register changed without a write");

  grp3_route_a: assert property (
    hit_a[3] == cmp_a_q[output_trigger_select[7:6]]
    && hit_b[3] == cmp_b_q[output_trigger_select[7:6]])
    else $error("group 3 routed from wrong channel");

  grp2_route_a: assert property (
    hit_a[2] == cmp_a_q[output_trigger_select[5:4]]
    && hit_b[2] == cmp_b_q[output_trigger_select[5:4]])
    else $error("group 2 routed from wrong channel");

  grp1_route_a: assert property (
    hit_a[1] == cmp_a_q[output_trigger_select[3:2]]
    && hit_b[1] == cmp_b_q[output_trigger_select[3:2]])
    else $error("group 1 routed from wrong channel");

  grp0_route_a: assert property (
    hit_a[0] == cmp_a_q[output_trigger_select[1:0]]
    && hit_b[0] == cmp_b_q[output_trigger_select[1:0]])
    else $error("group 0 routed from wrong channel");

  mode_ones_a: assert property (
    state == pot_pkg::POT_BUS_IDLE && i_avs_read
    && i_avs_address == pot_pkg::OFF_MODE
    |=> o_avs_readdata[7:4] == pot_pkg::MODE_ONES)
    else $error("reserved mode bits did not read as one");

  strobe_sample_a: assert property (
    i_cmp_a[0] && output_trigger_select[1:0] == 2'h0
    ##1 $stable(output_trigger_select) |-> hit_a[0])
    else $error("sampled strobe did not reach its group");

  ordinary_hold_a: assert property (
    !gap_mode[1] && !hit_a[1] && !wr_port
    |=> o_port_data[7:4] == $past(o_port_data[7:4]))
    else $error("ordinary group moved without match A");

  transfer_a: assert property (
    hit_a[2]
    |=> o_port_data[11:8] == (($past(port_base[11:8])
        & ~$past(staged_data_enable[11:8]))
        | ($past(staged_output_data[11:8])
        & $past(staged_data_enable[11:8]))))
    else $error("match A transfer wrong");

  gap_fall_a: assert property (
    gap_mode[3] && hit_b[3] && !hit_a[3] && !wr_port
    |=> o_port_data[15:12] == ($past(o_port_data[15:12])
        & ~($past(staged_data_enable[15:12])
        & ~$past(staged_output_data[15:12]))))
    else $error("match B did not clear only falling bits");

  bus_ack_a: assert property (
    state == pot_pkg::POT_BUS_IDLE && req
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest not a single low cycle");

  bus_idle_a: assert property (
    state == pot_pkg::POT_BUS_IDLE |-> o_avs_waitrequest)
    else $error("waitrequest low outside an acknowledge");

  trig_write_a: assert property (
    wr_trig |=> output_trigger_select == $past(i_avs_writedata[7:0]))
    else $error("trigger select write lost");

  mode_write_a: assert property (
    wr_mode |=> gap_mode == $past(i_avs_writedata[3:0]))
    else $error("mode register write lost");

  // a disabled bit may only move through a software port write
  disabled_hold_a: assert property (
    !wr_port
    |=> (o_port_data & ~$past(staged_data_enable))
        == ($past(o_port_data) & ~$past(staged_data_enable)))
    else $error("disabled port bit changed on a match");

  ordinary_b_a: assert property (
    !gap_mode[0] && hit_b[0] && !hit_a[0] && !wr_port
    |=> o_port_data[3:0] == $past(o_port_data[3:0]))
    else $error("ordinary group moved on match B");

  gap_rise_a: assert property (
    gap_mode[1] && hit_a[1] && !wr_port
    |=> o_port_data[7:4] == (($past(o_port_data[7:4])
        & ~$past(staged_data_enable[7:4]))
        | ($past(staged_output_data[7:4])
        & $past(staged_data_enable[7:4]))))
    else $error("match A in gap mode did not copy staged bits");

  cov_b_ignored_c: cover property (hit_b[0] && !gap_mode[0]);
  cov_transfer_c: cover property (hit_a[0] && staged_data_enable[0]);
  cov_gap_c:      cover property (gap_mode[3] && hit_b[3] ##[1:20] hit_a[3]);
  cov_write_c:    cover property (wr_trig);
  cov_read_c:     cover property (!o_avs_waitrequest && i_avs_read);
endmodule

//--- rtl/pot_pkg.sv
// constants, types and helpers shared by the pulse output trigger block
package pot_pkg;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned BE_W     = DATA_W / 8;
  localparam int unsigned GROUPS   = 4;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned GROUP_W  = 4;
  localparam int unsigned SEL_W    = 2;
  localparam int unsigned PORT_W   = GROUPS * GROUP_W;

  // register byte offsets on the bus
  localparam logic [ADDR_W-1:0] OFF_TRIG  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_NDATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_NEN   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PORT  = 8'h10;

  // reset values
  localparam logic [7:0]        TRIG_RST  = 8'hFF;
  localparam logic [7:0]        MODE_RST  = 8'hF0;
  localparam logic [3:0]        MODE_ONES = 4'hF;
  localparam logic [PORT_W-1:0] NDATA_RST = 16'h0000;
  localparam logic [PORT_W-1:0] NEN_RST   = 16'h0000;
  localparam logic [PORT_W-1:0] PORT_RST  = 16'h0000;

  typedef enum logic [1:0] {
    POT_BUS_IDLE = 2'b01,
    POT_BUS_ACK  = 2'b10
  } pot_bus_state_t;

  // two select bits of group g within the trigger register
  function automatic logic [SEL_W-1:0] trig_field(input logic [7:0] trig,
                                                  input int unsigned g);
    return trig[g*SEL_W +: SEL_W];
  endfunction

  // strobe of the channel chosen by sel
  function automatic logic chan_pick(input logic [CHANNELS-1:0] strobes,
                                     input logic [SEL_W-1:0]    sel);
    return strobes[sel];
  endfunction

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [PORT_W-1:0] lane_merge(
      input logic [PORT_W-1:0] old_v,
      input logic [DATA_W-1:0] wdata,
      input logic [BE_W-1:0]   be);
    logic [PORT_W-1:0] v;
    v = old_v;
    if (be[0]) v[7:0]  = wdata[7:0];
    if (be[1]) v[15:8] = wdata[15:8];
    return v;
  endfunction
endpackage

//--- rtl/pot_group.sv
// per-group trigger routing and next-data transfer for one 4-bit group
module pot_group #(
  parameter int unsigned CHANNELS = pot_pkg::CHANNELS,
  parameter int unsigned GROUP_W  = pot_pkg::GROUP_W
) (
  input  wire logic [pot_pkg::SEL_W-1:0] i_sel,
  input  wire logic                      i_gap_mode,
  input  wire logic [CHANNELS-1:0]       i_cmp_a,
  input  wire logic [CHANNELS-1:0]       i_cmp_b,
  input  wire logic [GROUP_W-1:0]        i_staged,
  input  wire logic [GROUP_W-1:0]        i_enable,
  input  wire logic [GROUP_W-1:0]        i_current,
  output logic      [GROUP_W-1:0]        o_next,
  output logic                           o_hit_a,
  output logic                           o_hit_b
);
  always_comb begin
    o_hit_a = pot_pkg::chan_pick(i_cmp_a, i_sel);
    o_hit_b = pot_pkg::chan_pick(i_cmp_b, i_sel);
    o_next  = i_current;
    if (o_hit_a) begin
      // full copy of enabled bits; a coincident B adds nothing
      o_next = (i_current & ~i_enable) | (i_staged & i_enable);
    end else if (o_hit_b && i_gap_mode) begin
      // only falling edges on B, rises wait for A, giving the gap
      o_next = i_current & ~(i_enable & ~i_staged);
    end
  end
endmodule

//--- test/pot_timer_model.sv
// timer unit stand-in that pulses compare-match strobes on command
module pot_timer_model #(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic                i_clock,
  output logic      [CHANNELS-1:0] o_cmp_a,
  output logic      [CHANNELS-1:0] o_cmp_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cmp_a = '0;
    o_cmp_b = '0;
  end
  // one-cycle strobes; in gap mode callers fire b (period) first and a
  // after the gap, as software sets registers b and a, or fire both in one call
  task automatic fire(input logic [CHANNELS-1:0] a,
                      input logic [CHANNELS-1:0] b);
    @(posedge i_clock);
    o_cmp_a <= a;
    o_cmp_b <= b;
    @(posedge i_clock);
    o_cmp_a <= '0;
    o_cmp_b <= '0;
  endtask
endmodule

//--- test/tb.sv
// self-checking bench for the pulse output trigger control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, rd, wr, wreq;
  logic [7:0]  addr, trig;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  be, cmp_a, cmp_b, mode;
  logic [15:0] port, en, staged, exp_port;
  int          err_total, total_checks;

  pot_ctrl uut (.i_clock(clk), .i_rst(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_cmp_a(cmp_a), .i_cmp_b(cmp_b),
    .o_port_data(port));
  pot_timer_model tm (.i_clock(clk), .o_cmp_a(cmp_a), .o_cmp_b(cmp_b));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr    <= w;
    rd    <= ~w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    rv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 20) begin
      err_total++;
      results();
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, rv);
  endtask

  // reference transfer: a copies enabled bits, b in gap mode clears enabled bits staged at zero
  task automatic xfer(input logic [3:0] a, input logic [3:0] b);
    logic [1:0] s;
    logic [3:0] m, n, p;
    tm.fire(a, b);
    repeat (2) @(negedge clk);
    for (int g = 0; g < 4; g++) begin
      s = trig[2*g +: 2];
      m = en[4*g +: 4];
      n = staged[4*g +: 4];
      p = exp_port[4*g +: 4];
      if (a[s])
        exp_port[4*g +: 4] = (n & m) | (p & ~m);
      else if (b[s] && mode[g])
        exp_port[4*g +: 4] = p & ~(m & ~n);
    end
    chk("port", {16'h0, exp_port}, {16'h0, port});
  endtask

  initial begin
    rst = 1'b1;
    {rd, wr, addr, wdata, be} = '0;
    err_total = 0;
    total_checks = 0;
    exp_port = 16'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk("trig", pot_pkg::OFF_TRIG, 32'hFF);
    rchk("mode", pot_pkg::OFF_MODE, 32'hF0);
    chk("port rst", 32'h0, {16'h0, port});
    bus(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
    rchk("unmapped", 8'h20, 32'h0);
    en = 16'h7FFE;
    bus(1'b1, pot_pkg::OFF_NEN, {16'h0, en}, 4'h3);
    rchk("nen", pot_pkg::OFF_NEN, {16'h0, en});
    bus(1'b1, pot_pkg::OFF_NDATA, 32'hFFFF, 4'h3);
    bus(1'b1, pot_pkg::OFF_NDATA, 32'h0, 4'h1);
    rchk("lanes", pot_pkg::OFF_NDATA, 32'hFF00);
    mode = 4'h0;
    bus(1'b1, pot_pkg::OFF_MODE, 32'hF0, 4'h1);
    rchk("mode ones", pot_pkg::OFF_MODE, 32'hF0);
    for (int c = 0; c < 4; c++) begin
      for (int g = 0; g < 4; g++) trig[2*g +: 2] = 2'(g + c);
      bus(1'b1, pot_pkg::OFF_TRIG, {24'h0, trig}, 4'h1);
      rchk("trig rw", pot_pkg::OFF_TRIG, {24'h0, trig});
      for (int ch = 0; ch < 4; ch++) begin
        staged = 16'(16'h1357 * (c * 4 + ch + 1));
        bus(1'b1, pot_pkg::OFF_NDATA, {16'h0, staged}, 4'h3);
        xfer(4'h0, 4'(1 << ch));
        xfer(4'(1 << ch), 4'h0);
      end
    end
    trig = 8'hFF;
    bus(1'b1, pot_pkg::OFF_TRIG, 32'hFF, 4'h1);
    for (int k = 0; k < 2; k++) begin
      mode = k ? 4'h5 : 4'hF;
      bus(1'b1, pot_pkg::OFF_MODE, {24'h0, 4'hF, mode}, 4'h1);
      rchk("gap mode", pot_pkg::OFF_MODE, {24'h0, 4'hF, mode});
      staged = k ? 16'h5A5A : 16'hA5C3;
      bus(1'b1, pot_pkg::OFF_NDATA, {16'h0, staged}, 4'h3);
      xfer(4'h0, 4'h8);
      // gap between b and a, as register a would give
      repeat (6) @(posedge clk);
      xfer(4'h8, 4'h0);
      staged = ~staged;
      bus(1'b1, pot_pkg::OFF_NDATA, {16'h0, staged}, 4'h3);
      xfer(4'h8, 4'h8);
    end
    rchk("trig kept", pot_pkg::OFF_TRIG, 32'hFF);
    rchk("mode kept", pot_pkg::OFF_MODE, 32'hF5);
    // a software port write, then a gap-mode clear on top of it
    exp_port = 16'h3C3C;
    bus(1'b1, pot_pkg::OFF_PORT, {16'h0, exp_port}, 4'h3);
    rchk("port rw", pot_pkg::OFF_PORT, {16'h0, exp_port});
    xfer(4'h0, 4'h8);
    results();
  end
endmodule
